// file: core/usb_tfc_cfg.svh
// register map, field positions, token types and timing counts for token/frame control
// ==========================================================================
// Functional notes
// - pingpong reset returns pointers to even bank
// - device mode: bit 0 enables module
// - host mode: bit 0 sends frame start each 1 ms
// - host enable toggle resets host logic
// - host resume clear appends low-speed end-of-packet
// - address bit 7 selects low speed
// - seven-bit device address held and used
// - received frame start captures 11-bit frame number
// - token type: setup 1101, in 1001, out 0001
// - token busy held while token executes
`ifndef USB_TFC_CFG_SVH
`define USB_TFC_CFG_SVH
// ==========================================================================
// offsets (byte addresses)
`define OFS_CONTROL 6'h00
`define OFS_ADDRESS 6'h04
`define OFS_FRAME_LOW 6'h08
`define OFS_FRAME_HIGH 6'h0c
`define OFS_TOKEN 6'h10
`define OFS_THRESHOLD 6'h14
// ==========================================================================
// control fields (low speed is bit 7 of the address register)
`define BIT_ENABLE 0
`define BIT_PP_RESET 1
`define BIT_RESUME 2
`define BIT_HOST_EN 3
`define BIT_BUSY 5
`define BIT_LOW_SPEED 7
// ==========================================================================
// token types
`define TOK_SETUP 4'hd
`define TOK_IN 4'h9
`define TOK_OUT 4'h1
// ==========================================================================
// timing
`define CLK_PERIOD_NS 40
`define FRAME_PERIOD_NS 1000000
`define FRAME_CYCLES (`FRAME_PERIOD_NS / `CLK_PERIOD_NS)
`define LS_BIT_NS 667
`define LS_EOP_CYCLES ((2 * `LS_BIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define THRESH_UNIT_CYCLES 8
`endif

// file: core/usb_tfc_pkg.sv
// shared types for token/frame control
package usb_tfc_pkg;
    typedef enum logic [3:0] {
        TOK_IDLE = 4'h1,
        TOK_WAIT = 4'h2,
        TOK_RUN = 4'h4,
        TOK_DONE = 4'h8
    } tok_state_t;
endpackage : usb_tfc_pkg

// file: core/usb_frame_timer.sv
// frame start interval timer with remaining-time output
`timescale 1ns/1ns
`default_nettype none
`include "usb_tfc_cfg.svh"
module usb_frame_timer #(
    parameter int FRAME_CYCLES = `FRAME_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_run,
    output logic o_tick,
    output logic [19:0] o_remain
);
    typedef struct packed {
        logic [19:0] cnt;
        logic tick;
    } timer_state_t;
    timer_state_t st_reg, st_next;
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (!i_run) begin
            st_next.cnt = 20'(FRAME_CYCLES - 1);
        end else if (st_reg.cnt == 20'h00000) begin
            st_next.cnt = 20'(FRAME_CYCLES - 1);
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt = st_reg.cnt - 20'h00001;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign o_tick = st_reg.tick;
    assign o_remain = st_reg.cnt;
endmodule : usb_frame_timer
`default_nettype wire

// file: core/usb_sync2.sv
// two-flop synchroniser for a level
`timescale 1ns/1ns
`default_nettype none
module usb_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;
    sync_state_t st_reg, st_next;
    always_comb begin
        st_next.first = i_async;
        st_next.second = st_reg.first;
    end
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign o_sync = st_reg.second;
endmodule : usb_sync2
`default_nettype wire

// file: core/usb_token_frame_control.sv
// token issue, frame start and frame number control with avalon-mm registers
`timescale 1ns/1ns
`default_nettype none
`include "usb_tfc_cfg.svh"
module usb_token_frame_control #(
    parameter int FRAME_CYCLES = `FRAME_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    // ======================================================================
    // avalon-mm slave
    input wire logic [5:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // ======================================================================
    // link side (pins, other domain)
    input wire logic i_sof_received,
    input wire logic [10:0] i_rx_frame_number,
    input wire logic i_token_done,
    // ======================================================================
    // core outputs
    output logic o_module_enable,
    output logic o_pingpong_pointer_reset,
    output logic o_host_logic_reset,
    output logic o_frame_start_tx,
    output logic o_token_start,
    output logic [3:0] o_token_pid,
    output logic [3:0] o_endpoint_field,
    output logic [6:0] o_bus_device_address,
    output logic o_low_speed_select,
    output logic o_resume_drive,
    output logic o_ls_eop_drive
);
    typedef struct packed {
        logic module_enable_bit;
        logic pingpong_pointer_reset;
        logic resume;
        logic host_mode_enable;
        logic token_in_progress;
        logic low_speed_select;
        logic [6:0] bus_device_address;
        logic [7:0] frame_count_low;
        logic [2:0] frame_count_high;
        logic [7:0] token_command;
        logic [7:0] threshold_count;
        usb_tfc_pkg::tok_state_t tok_state;
        logic [7:0] eop_cnt;
        logic sof_prev;
        logic done_prev;
        logic ack;
        logic [31:0] rdata;
        logic host_reset;
        logic sof_tx;
        logic tok_start;
        logic tok_ls;
    } ctl_state_t;
    ctl_state_t st_reg, st_next;
    logic sof_s;
    logic done_s;
    logic [10:0] frame_s;
    logic tick;
    logic [19:0] remain;
    logic acc;
    logic wr;
    // ======================================================================
    // pin synchronisers
    usb_sync2 #(.WIDTH(13)) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_async({i_sof_received, i_token_done, i_rx_frame_number}),
        .o_sync({sof_s, done_s, frame_s})
    );
    usb_frame_timer #(.FRAME_CYCLES(FRAME_CYCLES)) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_run(st_reg.host_mode_enable && st_reg.module_enable_bit),
        .o_tick(tick),
        .o_remain(remain)
    );
    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nv,
                                          input logic be);
        merge8 = be ? nv : old;
    endfunction : merge8
    function automatic logic valid_pid(input logic [3:0] pid);
        valid_pid = (pid == `TOK_SETUP) || (pid == `TOK_IN) || (pid == `TOK_OUT);
    endfunction : valid_pid
    // one wait state: each access answered on the second edge
    assign acc = (i_read || i_write) && !st_reg.ack;
    assign wr = i_write && st_reg.ack;
    always_comb begin
        logic [7:0] ctl_w;
        logic [7:0] ctl_r;
        logic threshold_ok;
        ctl_w = 8'h00;
        ctl_r = 8'h00;
        st_next = st_reg;
        st_next.ack = acc;
        st_next.host_reset = 1'b0;
        st_next.sof_tx = 1'b0;
        st_next.tok_start = 1'b0;
        st_next.sof_prev = sof_s;
        st_next.done_prev = done_s;
        // frame start too close: hold off new tokens
        threshold_ok = remain > (20'(st_reg.threshold_count) * 20'(`THRESH_UNIT_CYCLES));
        if (sof_s && !st_reg.sof_prev) begin
            st_next.frame_count_low = frame_s[7:0];
            st_next.frame_count_high = frame_s[10:8];
        end
        if (tick && st_reg.host_mode_enable && st_reg.module_enable_bit) begin
            st_next.sof_tx = 1'b1;
        end
        case (st_reg.tok_state)
            usb_tfc_pkg::TOK_IDLE: begin
            end
            usb_tfc_pkg::TOK_WAIT: begin
                if (threshold_ok) begin
                    st_next.tok_start = 1'b1;
                    st_next.tok_ls = st_reg.low_speed_select;
                    st_next.tok_state = usb_tfc_pkg::TOK_RUN;
                end
            end
            usb_tfc_pkg::TOK_RUN: begin
                if (done_s && !st_reg.done_prev) begin
                    st_next.tok_state = usb_tfc_pkg::TOK_DONE;
                end
            end
            usb_tfc_pkg::TOK_DONE: begin
                st_next.token_in_progress = 1'b0;
                st_next.tok_state = usb_tfc_pkg::TOK_IDLE;
            end
            default: begin
                st_next.tok_state = usb_tfc_pkg::TOK_IDLE;
            end
        endcase
        if (st_reg.eop_cnt != 8'h00) begin
            st_next.eop_cnt = st_reg.eop_cnt - 8'h01;
        end
        ctl_r[`BIT_ENABLE] = st_reg.module_enable_bit;
        ctl_r[`BIT_PP_RESET] = st_reg.pingpong_pointer_reset;
        ctl_r[`BIT_RESUME] = st_reg.resume;
        ctl_r[`BIT_HOST_EN] = st_reg.host_mode_enable;
        ctl_r[`BIT_BUSY] = st_reg.token_in_progress;
        if (wr && i_address == `OFS_CONTROL && i_byteenable[0]) begin
            ctl_w = i_writedata[7:0];
            st_next.module_enable_bit = ctl_w[`BIT_ENABLE];
            st_next.pingpong_pointer_reset = ctl_w[`BIT_PP_RESET];
            st_next.resume = ctl_w[`BIT_RESUME];
            st_next.host_mode_enable = ctl_w[`BIT_HOST_EN];
            if (st_reg.resume && !ctl_w[`BIT_RESUME] && st_reg.host_mode_enable) begin
                st_next.eop_cnt = 8'(`LS_EOP_CYCLES);
            end
            if (ctl_w[`BIT_HOST_EN] != st_reg.host_mode_enable) begin
                st_next.host_reset = 1'b1;
                st_next.token_in_progress = 1'b0;
                st_next.tok_state = usb_tfc_pkg::TOK_IDLE;
                st_next.eop_cnt = 8'h00;
            end
        end
        if (wr && i_address == `OFS_ADDRESS) begin
            st_next.low_speed_select = i_byteenable[0] ? i_writedata[7] : st_reg.low_speed_select;
            st_next.bus_device_address = i_byteenable[0] ? i_writedata[6:0]
                                                         : st_reg.bus_device_address;
        end
        if (wr && i_address == `OFS_THRESHOLD) begin
            st_next.threshold_count = merge8(st_reg.threshold_count, i_writedata[7:0],
                                             i_byteenable[0]);
        end
        if (wr && i_address == `OFS_TOKEN && i_byteenable[0]) begin
            st_next.token_command = i_writedata[7:0];
            // reserved types and writes while busy are stored but launch no token
            if (st_reg.host_mode_enable && !st_reg.token_in_progress
                && valid_pid(i_writedata[7:4])) begin
                st_next.token_in_progress = 1'b1;
                st_next.tok_state = usb_tfc_pkg::TOK_WAIT;
            end
        end
        st_next.rdata = 32'h00000000;
        if (acc && i_read) begin
            case (i_address)
                `OFS_CONTROL: st_next.rdata = {24'h000000, ctl_r};
                `OFS_ADDRESS: st_next.rdata = {24'h000000, st_reg.low_speed_select,
                                               st_reg.bus_device_address};
                `OFS_FRAME_LOW: st_next.rdata = {24'h000000, st_reg.frame_count_low};
                `OFS_FRAME_HIGH: st_next.rdata = {29'h00000000, st_reg.frame_count_high};
                `OFS_TOKEN: st_next.rdata = {24'h000000, st_reg.token_command};
                `OFS_THRESHOLD: st_next.rdata = {24'h000000, st_reg.threshold_count};
                default: st_next.rdata = 32'h00000000;
            endcase
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= '0;
            st_reg.tok_state <= usb_tfc_pkg::TOK_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end
    // ======================================================================
    // outputs
    assign o_readdata = st_reg.rdata;
    assign o_waitrequest = !st_reg.ack;
    assign o_module_enable = st_reg.module_enable_bit;
    assign o_pingpong_pointer_reset = st_reg.pingpong_pointer_reset;
    assign o_host_logic_reset = st_reg.host_reset;
    assign o_frame_start_tx = st_reg.sof_tx;
    assign o_token_start = st_reg.tok_start;
    assign o_token_pid = st_reg.token_command[7:4];
    assign o_endpoint_field = st_reg.token_command[3:0];
    assign o_bus_device_address = st_reg.bus_device_address;
    assign o_low_speed_select = st_reg.tok_ls;
    assign o_resume_drive = st_reg.resume;
    assign o_ls_eop_drive = st_reg.eop_cnt != 8'h00;
    // ======================================================================
    // checks
    chk_busy_set_on_token: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (wr && i_address == `OFS_TOKEN && i_byteenable[0] && st_reg.host_mode_enable
         && !st_reg.token_in_progress && valid_pid(i_writedata[7:4]))
        |=> st_reg.token_in_progress) else $error("token busy not set");
    chk_host_toggle_reset: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (st_reg.host_mode_enable != $past(st_reg.host_mode_enable))
        |-> o_host_logic_reset && !st_reg.token_in_progress)
        else $error("host toggle without reset");
    chk_sof_needs_host: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_frame_start_tx |-> $past(st_reg.host_mode_enable && st_reg.module_enable_bit))
        else $error("frame start outside host mode");
    chk_frame_capture: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        (sof_s && !st_reg.sof_prev) |=> st_reg.frame_count_low == $past(frame_s[7:0])
        && st_reg.frame_count_high == $past(frame_s[10:8]))
        else $error("frame number not captured");
    chk_eop_after_resume: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        ($fell(st_reg.resume) && $past(st_reg.host_mode_enable)
         && st_reg.host_mode_enable) |-> o_ls_eop_drive [*2])
        else $error("no low-speed eop after resume");
    chk_token_threshold: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_token_start |-> $past(remain) > 20'($past(st_reg.threshold_count)) * 20'd8)
        else $error("token started inside threshold");
    chk_reserved_pid: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        o_token_start |-> valid_pid(o_token_pid))
        else $error("reserved token type started");
    chk_bus_answer: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        ($rose(i_read || i_write) && o_waitrequest) |=> !o_waitrequest)
        else $error("bus answer late");
endmodule : usb_token_frame_control
`default_nettype wire

// file: testbench/usb_link_partner.sv
// far-side model: sends frame starts and completes launched tokens
`timescale 1ns/1ns
`default_nettype none
module usb_link_partner (
    input wire logic i_ref_clk,
    input wire logic i_token_start,
    input wire logic i_slow,
    input wire logic i_sof_go,
    input wire logic [10:0] i_frame,
    output logic o_sof_received,
    output logic [10:0] o_rx_frame_number,
    output logic o_token_done
);
    logic [3:0] sof_cnt = 4'h0;
    logic [5:0] tok_cnt = 6'h0;
    initial begin
        o_sof_received = 1'b0;
        o_rx_frame_number = 11'h2aa;
        o_token_done = 1'b0;
    end
    // number set up before the flag, held past its fall, then scrambled
    always @(posedge i_ref_clk) begin
        if (i_sof_go) begin
            o_rx_frame_number <= i_frame;
        end else if (sof_cnt == 4'h1) begin
            o_rx_frame_number <= ~o_rx_frame_number;
        end
        sof_cnt <= i_sof_go ? 4'hc : sof_cnt - 4'(sof_cnt != 4'h0);
        o_sof_received <= sof_cnt > 4'h4 && sof_cnt < 4'hb;
    end
    // answers each token promptly or after a long stall
    always @(posedge i_ref_clk) begin
        if (i_token_start) begin
            tok_cnt <= i_slow ? 6'h18 : 6'h06;
        end else if (tok_cnt != 6'h0) begin
            tok_cnt <= tok_cnt - 6'h1;
        end
        o_token_done <= tok_cnt != 6'h0 && tok_cnt < 6'h05;
    end
endmodule : usb_link_partner
`default_nettype wire

// file: testbench/usb_token_frame_control_test.sv
// self-checking bench for token and frame control
`timescale 1ns/1ns
`default_nettype none
`include "usb_tfc_cfg.svh"
module usb_token_frame_control_test;
    localparam int FC = 100;
    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [5:0] i_address = 6'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [3:0] i_byteenable = 4'h1;
    logic [31:0] o_readdata;
    logic [10:0] i_rx_frame_number;
    logic [3:0] o_token_pid, o_endpoint_field;
    logic [6:0] o_bus_device_address;
    logic o_waitrequest, i_sof_received, i_token_done, o_module_enable, o_token_start;
    logic o_pingpong_pointer_reset, o_host_logic_reset, o_frame_start_tx;
    logic o_low_speed_select, o_resume_drive, o_ls_eop_drive;
    logic slow = 1'b0;
    logic sof_go = 1'b0;
    logic [10:0] frame = 11'h0;
    int errors = 0, compares = 0, n_sof = 0, n_tok = 0, n_hrst = 0, n_eop = 0;
    int seed = 32'h3620;
    logic [31:0] exp_q[$], tok_q[$];
    wire logic [8:0] tok_seen = {o_token_pid, o_endpoint_field, o_low_speed_select};
    always #20 i_ref_clk = ~i_ref_clk;
    usb_token_frame_control #(.FRAME_CYCLES(FC)) DUT (
        .i_ref_clk, .i_resetn, .i_address, .i_read, .i_write, .i_writedata, .i_byteenable,
        .o_readdata, .o_waitrequest, .i_sof_received, .i_rx_frame_number, .i_token_done,
        .o_module_enable, .o_pingpong_pointer_reset, .o_host_logic_reset, .o_frame_start_tx,
        .o_token_start, .o_token_pid, .o_endpoint_field, .o_bus_device_address,
        .o_low_speed_select, .o_resume_drive, .o_ls_eop_drive
    );
    usb_link_partner link (
        .i_ref_clk, .i_token_start(o_token_start), .i_slow(slow), .i_sof_go(sof_go),
        .i_frame(frame), .o_sof_received(i_sof_received),
        .o_rx_frame_number(i_rx_frame_number), .o_token_done(i_token_done)
    );
    // ======================================================================
    // tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic results();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    // waitrequest and readdata are taken at the rising edge where waitrequest is low
    task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        i_address <= a;
        i_writedata <= d;
        i_read <= rd;
        i_write <= !rd;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 20);
        q = o_readdata;
        if (n >= 20) begin
            errors++;
            results();
        end
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        exp_q.push_back(e);
        bus(1'b1, a, 32'h0, q);
    endtask : rd
    task automatic idle();
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            bus(1'b1, `OFS_CONTROL, 32'h0, q);
            n++;
        end while (q[5] !== 1'b0 && n < 40);
        if (n >= 40) begin
            errors++;
            results();
        end
    endtask : idle
    task automatic ticks(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : ticks
    // ======================================================================
    // result watcher: polls of busy push no note and are skipped
    always @(posedge i_ref_clk) begin
        if (i_read && o_waitrequest === 1'b0 && exp_q.size() > 0) begin
            chk("readdata", exp_q.pop_front(), o_readdata);
        end
        if (o_token_start === 1'b1) begin
            n_tok++;
            chk("token", tok_q.pop_front(), {23'h0, tok_seen});
        end
        n_sof += int'(o_frame_start_tx === 1'b1);
        n_hrst += int'(o_host_logic_reset === 1'b1);
        n_eop += int'(o_ls_eop_drive === 1'b1);
    end
    // ======================================================================
    // main sequence
    initial begin
        logic [31:0] d;
        int h;
        int s;
        logic [3:0] pids [3];
        logic [7:0] thr [5];
        pids = '{4'hd, 4'h9, 4'h1};
        thr = '{8'h4a, 8'h2a, 8'h1a, 8'h12, 8'hff};
        repeat (12) @(posedge i_ref_clk);
        chk("waitrequest", 32'h1, {31'h0, o_waitrequest});
        i_resetn <= 1'b1;
        for (int a = 0; a < 7; a++) rd(6'(a * 4), 32'h0);
        d = $random(seed);
        wr(`OFS_ADDRESS, d);
        rd(`OFS_ADDRESS, {24'h0, d[7:0]});
        chk("address", {25'h0, d[6:0]}, {25'h0, o_bus_device_address});
        h = n_hrst;
        wr(`OFS_CONTROL, 32'h3);
        ticks(2);
        chk("enable", 32'h3, {30'h0, o_pingpong_pointer_reset, o_module_enable});
        s = n_sof;
        ticks(3 * FC);
        chk("sof off", s, n_sof);
        wr(`OFS_CONTROL, 32'h0);
        ticks(2);
        chk("enable", 32'h0, {30'h0, o_pingpong_pointer_reset, o_module_enable});
        wr(`OFS_CONTROL, 32'h8);
        wr(`OFS_CONTROL, 32'h9);
        ticks(2);
        chk("host reset", h + 1, n_hrst);
        s = n_sof;
        // first frame start lands about one frame (FC cycles) after the count window opens
        ticks(5 * FC + 5);
        chk("sof count", s + 5, n_sof);
        for (int k = 0; k < 3; k++) begin
            d = $random(seed);
            slow <= k == 1;
            wr(`OFS_ADDRESS, {24'h0, d[7:0]});
            tok_q.push_back({23'h0, pids[k], d[11:8], d[7]});
            wr(`OFS_TOKEN, {24'h0, pids[k], d[11:8]});
            rd(`OFS_CONTROL, 32'h29);
            wr(`OFS_ADDRESS, {24'h0, ~d[7], d[6:0]});
            idle();
        end
        chk("launches", 3, n_tok);
        // reserved type written on purpose: stored but never launched
        wr(`OFS_TOKEN, 32'h53);
        rd(`OFS_TOKEN, 32'h53);
        rd(`OFS_CONTROL, 32'h09);
        foreach (thr[i]) begin
            wr(`OFS_THRESHOLD, {24'h0, thr[i]});
            rd(`OFS_THRESHOLD, {24'h0, thr[i]});
        end
        wr(`OFS_TOKEN, 32'h92);
        ticks(3 * FC);
        chk("held", 3, n_tok);
        rd(`OFS_CONTROL, 32'h29);
        h = n_hrst;
        wr(`OFS_CONTROL, 32'h1);
        rd(`OFS_CONTROL, 32'h01);
        chk("host reset", h + 1, n_hrst);
        repeat (2) begin
            @(posedge i_ref_clk);
            frame <= 11'($random(seed));
            sof_go <= 1'b1;
            @(posedge i_ref_clk);
            sof_go <= 1'b0;
            ticks(20);
            rd(`OFS_FRAME_LOW, {24'h0, frame[7:0]});
            rd(`OFS_FRAME_HIGH, {29'h0, frame[10:8]});
        end
        wr(`OFS_CONTROL, 32'hc);
        ticks(2);
        chk("resume", 32'h1, {31'h0, o_resume_drive});
        s = n_eop;
        wr(`OFS_CONTROL, 32'h8);
        ticks(60);
        chk("eop", s + 34, n_eop);
        chk("launches", 3, n_tok);
        results();
    end
endmodule : usb_token_frame_control_test
`default_nettype wire
